//--- include/pixel_link_regs.svh
// Purpose: Constants for the parallel pixel link ends and their FIFO
// Assumes: One system clock of 50 MHz drives every flip-flop
// Notes: Field positions, counts and timing figures of the link are defined here
//
// Overview of operation
// - Carry 24 data, clock, three controls
// - Receiver locks alone after live insertion
// - Native map: red, green, blue bytes
// - 18-bit map, syncs on control lines
// - 18-bit map, syncs inside data word
// - Index 7 is colour MSB, 0 LSB
// - Edge select low captures on falling edge
// - Both configuration selects held low
// - Display samples on recovered clock edge
// - Edge select high captures on rising edge
// - Output strobe select low means falling strobe
`ifndef PIXEL_LINK_REGS_SVH
`define PIXEL_LINK_REGS_SVH

// Word widths
`define PIX_DATA_W 24
`define PIX_CTRL_W 3
`define LINK_WORD_W 27
`define FIFO_DEPTH 16

// Native 24-bit field positions
`define M24_RED_LSB 0
`define M24_GREEN_LSB 8
`define M24_BLUE_LSB 16

// 18-bit map, syncs on control lines
`define M18C_SPARE01_LSB 0
`define M18C_RED_LSB 2
`define M18C_SPARE23_LSB 8
`define M18C_GREEN_LSB 10
`define M18C_SPARE45_LSB 16
`define M18C_BLUE_LSB 18

// 18-bit map, syncs in the data word
`define M18E_RED_LSB 0
`define M18E_GREEN_LSB 6
`define M18E_BLUE_LSB 12
`define M18E_LSYNC_BIT 18
`define M18E_FSYNC_BIT 19
`define M18E_PVALID_BIT 20
`define M18E_SPARE_LSB 21

// Control line positions (lines 1, 2, 3)
`define CTRL_LSYNC_BIT 0
`define CTRL_FSYNC_BIT 1
`define CTRL_PVALID_BIT 2

// Strap values and reset values
`define CONFIG_COMPANION 2'h0
`define LINK_WORD_RESET 27'h000_0000

// Timing
`define CLK_PERIOD_NS 20
`define PIX_HALF_CYCLES 6
`define OUT_HALF_CYCLES 2
`define LOCK_EDGES 4
`define LOSS_TIME_NS 10000
`define LOSS_CYCLES (`LOSS_TIME_NS / `CLK_PERIOD_NS)
`define FIFO_MARGIN 4

`endif

//--- include/pixel_link_pkg.sv
// Purpose: Types and colour mapping functions for the pixel link
// Assumes: pixel_link_regs.svh gives the field positions
// Notes: Six-bit colour modes use bits 5..0 of each component
`include "pixel_link_regs.svh"

package pixel_link_pkg;

  // Colour and data mapping scenarios
  typedef enum logic [1:0] {
    MAP_NATIVE_24 = 2'h0,
    MAP_18_CTRL = 2'h1,
    MAP_18_EMBED = 2'h2
  } map_mode_t;

  // One pixel on the user side, index 7 of a colour is its MSB
  typedef struct packed {
    logic [5:0] spare_signal;
    logic pixel_valid;
    logic frame_sync;
    logic line_sync;
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
  } pixel_t;

  // One word as it crosses the link
  typedef struct packed {
    logic [`PIX_CTRL_W-1:0] control_line;
    logic [`PIX_DATA_W-1:0] parallel_word;
  } link_word_t;

  // Pixel to link word for the chosen scenario
  function automatic link_word_t pack_pixel(map_mode_t m, pixel_t p);
    link_word_t w;
    w = '0;
    case (m)
      MAP_18_CTRL: begin
        w.parallel_word = {p.blue[5:0], p.spare_signal[5:4],
                           p.green[5:0], p.spare_signal[3:2],
                           p.red[5:0], p.spare_signal[1:0]};
        w.control_line = {p.pixel_valid, p.frame_sync,
                          p.line_sync};
      end
      MAP_18_EMBED: begin
        w.parallel_word = {p.spare_signal[2:0], p.pixel_valid,
                           p.frame_sync, p.line_sync, p.blue[5:0],
                           p.green[5:0], p.red[5:0]};
        w.control_line = 3'h0;
      end
      default: begin
        w.parallel_word = {p.blue, p.green, p.red};
        w.control_line = {p.pixel_valid, p.frame_sync,
                          p.line_sync};
      end
    endcase
    return w;
  endfunction

  // Link word back to a pixel for the chosen scenario
  function automatic pixel_t unpack_pixel(map_mode_t m, link_word_t w);
    pixel_t p;
    p = '0;
    case (m)
      MAP_18_CTRL: begin
        p.red[5:0] = w.parallel_word[`M18C_RED_LSB +: 6];
        p.green[5:0] = w.parallel_word[`M18C_GREEN_LSB +: 6];
        p.blue[5:0] = w.parallel_word[`M18C_BLUE_LSB +: 6];
        p.spare_signal = {w.parallel_word[`M18C_SPARE45_LSB +: 2],
                          w.parallel_word[`M18C_SPARE23_LSB +: 2],
                          w.parallel_word[`M18C_SPARE01_LSB +: 2]};
        p.line_sync = w.control_line[`CTRL_LSYNC_BIT];
        p.frame_sync = w.control_line[`CTRL_FSYNC_BIT];
        p.pixel_valid = w.control_line[`CTRL_PVALID_BIT];
      end
      MAP_18_EMBED: begin
        p.red[5:0] = w.parallel_word[`M18E_RED_LSB +: 6];
        p.green[5:0] = w.parallel_word[`M18E_GREEN_LSB +: 6];
        p.blue[5:0] = w.parallel_word[`M18E_BLUE_LSB +: 6];
        p.line_sync = w.parallel_word[`M18E_LSYNC_BIT];
        p.frame_sync = w.parallel_word[`M18E_FSYNC_BIT];
        p.pixel_valid = w.parallel_word[`M18E_PVALID_BIT];
        p.spare_signal[2:0] = w.parallel_word[`M18E_SPARE_LSB +: 3];
      end
      default: begin
        p.red = w.parallel_word[`M24_RED_LSB +: 8];
        p.green = w.parallel_word[`M24_GREEN_LSB +: 8];
        p.blue = w.parallel_word[`M24_BLUE_LSB +: 8];
        p.line_sync = w.control_line[`CTRL_LSYNC_BIT];
        p.frame_sync = w.control_line[`CTRL_FSYNC_BIT];
        p.pixel_valid = w.control_line[`CTRL_PVALID_BIT];
      end
    endcase
    return p;
  endfunction

endpackage

//--- include/pixel_link_if.sv
// Purpose: Parallel pins between the link device and its partner
// Assumes: Both ends run on the same system clock
// Notes: Partner drives host pins, straps and display ready, device drives the rest
`include "pixel_link_regs.svh"

interface pixel_link_if;
  logic pixel_clock_in;
  logic [`PIX_DATA_W-1:0] parallel_word_in;
  logic [`PIX_CTRL_W-1:0] control_line_in;
  logic ser_edge_select;
  logic des_edge_select;
  logic [1:0] link_config;
  logic display_ready;
  logic link_ready;
  logic recovered_clock_out;
  logic [`PIX_DATA_W-1:0] parallel_word_out;
  logic [`PIX_CTRL_W-1:0] control_line_out;

  // Serializer and deserializer pair
  modport device (
    input pixel_clock_in, parallel_word_in, control_line_in,
    input ser_edge_select, des_edge_select, link_config, display_ready,
    output link_ready, recovered_clock_out, parallel_word_out,
    output control_line_out
  );

  // Host source and display target
  modport partner (
    output pixel_clock_in, parallel_word_in, control_line_in,
    output ser_edge_select, des_edge_select, link_config, display_ready,
    input link_ready, recovered_clock_out, parallel_word_out,
    input control_line_out
  );
endinterface

//--- design/pixel_fifo.sv
// Purpose: Word FIFO between pixel capture and output strobing
// Assumes: Same clock on both sides
// Notes: Level output lets the writer stall its source early
module pixel_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  input wire logic i_clock, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_clock_en, // Freezes state when low
  input wire logic [WIDTH-1:0] i_in_data, // Write data
  input wire logic i_in_valid, // Write request
  output logic o_in_ready, // Not full
  output logic [WIDTH-1:0] o_out_data, // Head word
  output logic o_out_valid, // Not empty
  input wire logic i_out_ready, // Read request
  output logic [$clog2(DEPTH):0] o_level // Words held
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  // Honest flags from pointer difference
  assign o_level = wr_ptr - rd_ptr;
  assign o_in_ready = (o_level != DEPTH[AW:0]);
  assign o_out_valid = (wr_ptr != rd_ptr);
  assign o_out_data = mem[rd_ptr[AW-1:0]];

  // Pointer update
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (i_clock_en) begin
      if (push) wr_ptr <= wr_ptr + 1'h1;
      if (pop) rd_ptr <= rd_ptr + 1'h1;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge i_clock) begin
    if (i_clock_en && push) mem[wr_ptr[AW-1:0]] <= i_in_data;
  end
endmodule

//--- design/pixel_link_device.sv
// Purpose: Serializer capture and deserializer output of the pixel link
// Assumes: Pixel clock is a pin, sampled by the system clock
// Notes: Pixel clock half period must span at least four system clocks
`include "pixel_link_regs.svh"

module pixel_link_device
  import pixel_link_pkg::*;
(
  input wire logic i_clock, // System clock, 50 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_clock_en, // Freezes all state when low
  pixel_link_if.device link, // Pins to host and display
  output logic o_locked, // Receiver lock state
  output logic o_overflow // Sticky: word lost on full FIFO
);

  // Output strobe sequence
  typedef enum logic [1:0] {
    OUT_IDLE = 2'h0,
    OUT_SETUP = 2'h1,
    OUT_STROBE = 2'h2
  } out_state_t;

  localparam int LVL_W = $clog2(`FIFO_DEPTH) + 1;

  logic [2:0] clk_sync;
  link_word_t data_pipe [3];
  logic pclk_level;
  logic ser_rising;
  logic des_rising;
  logic [2:0] edge_count;
  logic [9:0] idle_count;
  logic locked;
  logic overflow;
  logic link_ready;
  out_state_t state;
  out_state_t next_state;
  logic [2:0] half_count;
  logic rclk;
  link_word_t out_word;
  link_word_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [LVL_W-1:0] fifo_level;

  // Pin straps, held static by the system
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ser_rising <= 1'h0;
      des_rising <= 1'h0;
    end else if (i_clock_en) begin
      ser_rising <= link.ser_edge_select;
      des_rising <= link.des_edge_select;
    end
  end

  // Three-stage sampling of the pixel clock pin
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      clk_sync <= 3'h7; // Pin resets high, so no false edge
    end else if (i_clock_en) begin
      clk_sync <= {clk_sync[1:0], link.pixel_clock_in};
    end
  end

  // Data delayed alongside the clock samples
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < 3; i++) data_pipe[i] <= `LINK_WORD_RESET;
    end else if (i_clock_en) begin
      data_pipe[0] <= {link.control_line_in, link.parallel_word_in};
      data_pipe[1] <= data_pipe[0];
      data_pipe[2] <= data_pipe[1];
    end
  end

  // Edge counts once stages two and three agree
  wire stages_agree = (clk_sync[1] == clk_sync[2]);
  wire pclk_changed = stages_agree && (clk_sync[2] != pclk_level);
  wire pclk_rise = pclk_changed && clk_sync[2];
  wire pclk_fall = pclk_changed && !clk_sync[2];
  wire capture = ser_rising ? pclk_rise : pclk_fall;

  // Filtered pixel clock level
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pclk_level <= 1'h1;
    end else if (i_clock_en && pclk_changed) begin
      pclk_level <= clk_sync[2];
    end
  end

  // Lock after a run of edges, no reference or pattern needed
  wire lock_reached = (edge_count == 3'(`LOCK_EDGES - 1));
  wire link_lost = (idle_count == 10'(`LOSS_CYCLES - 1));

  // Lock tracker, drops on a long silence and relocks alone
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      edge_count <= 3'h0;
      idle_count <= 10'h000;
      locked <= 1'h0;
    end else if (i_clock_en) begin
      if (capture) begin
        idle_count <= 10'h000;
        if (!locked) begin
          edge_count <= edge_count + 3'h1;
          if (lock_reached) locked <= 1'h1;
        end
      end else if (link_lost) begin
        locked <= 1'h0;
        edge_count <= 3'h0;
        idle_count <= 10'h000;
      end else if (locked) begin
        idle_count <= idle_count + 10'h001;
      end
    end
  end

  // Captured words enter the FIFO only while locked
  wire push = capture && locked;
  wire pop = (state == OUT_IDLE) && fifo_out_valid && link.display_ready;

  pixel_fifo #(
    .WIDTH(`LINK_WORD_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clock_en(i_clock_en),
    .i_in_data(data_pipe[2]),
    .i_in_valid(push),
    .o_in_ready(fifo_in_ready),
    .o_out_data(fifo_out),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop),
    .o_level(fifo_level)
  );

  // Source back-pressure and lost-word flag
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      link_ready <= 1'h0;
      overflow <= 1'h0;
    end else if (i_clock_en) begin
      link_ready <= fifo_level < LVL_W'(`FIFO_DEPTH - `FIFO_MARGIN);
      if (push && !fifo_in_ready) overflow <= 1'h1;
    end
  end

  // Idle level of the recovered clock is the non-strobe level
  wire rclk_idle = !des_rising;
  wire half_done = (half_count == 3'(`OUT_HALF_CYCLES - 1));

  // Output sequence: present word, then make the strobe edge
  always_comb begin
    next_state = state;
    case (state)
      OUT_IDLE: if (pop) next_state = OUT_SETUP;
      OUT_SETUP: if (half_done) next_state = OUT_STROBE;
      OUT_STROBE: if (half_done) next_state = OUT_IDLE;
      default: next_state = OUT_IDLE;
    endcase
  end

  // Output state, timer and recovered clock
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= OUT_IDLE;
      half_count <= 3'h0;
      rclk <= 1'h1;
    end else if (i_clock_en) begin
      state <= next_state;
      if (state == OUT_IDLE || half_done) half_count <= 3'h0;
      else half_count <= half_count + 3'h1;
      if (state == OUT_SETUP && half_done) rclk <= !rclk_idle;
      else if (state != OUT_STROBE) rclk <= rclk_idle;
    end
  end

  // Output word stands from pop until the next pop
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      out_word <= `LINK_WORD_RESET;
    end else if (i_clock_en && pop) begin
      out_word <= fifo_out;
    end
  end

  // Outputs straight from flip-flops
  assign link.recovered_clock_out = rclk;
  assign link.parallel_word_out = out_word.parallel_word;
  assign link.control_line_out = out_word.control_line;
  assign link.link_ready = link_ready;
  assign o_locked = locked;
  assign o_overflow = overflow;

endmodule

//--- design/pixel_link_partner.sv
// Purpose: Host source and display sink facing the pixel link
// Assumes: Device end shares the system clock
// Notes: Host makes the pixel clock by counting system clocks
`include "pixel_link_regs.svh"

module pixel_link_partner
  import pixel_link_pkg::*;
(
  input wire logic i_clock, // System clock, 50 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_clock_en, // Freezes all state when low
  input wire map_mode_t i_map_mode, // Colour mapping scenario
  input wire logic i_capture_rising, // Serializer edge select
  input wire logic i_strobe_rising, // Deserializer edge select
  input wire pixel_t i_tx_pixel, // Pixel to send
  input wire logic i_tx_valid, // Pixel offered
  output logic o_tx_ready, // Pixel taken when valid
  output pixel_t o_rx_pixel, // Pixel received
  output logic o_rx_valid, // One-cycle receive pulse
  input wire logic i_rx_ready, // Display can take words
  pixel_link_if.partner link // Pins to the device
);

  // Pixel clock generation
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_SETUP = 2'h1,
    TX_HOLD = 2'h2
  } tx_state_t;

  tx_state_t state;
  logic [2:0] half_count;
  logic pclk;
  logic tx_ready;
  link_word_t tx_word;
  logic cap_rising;
  logic strobe_rising;
  logic [1:0] config_sel;
  logic disp_ready;
  logic rclk_prev;
  pixel_t rx_pixel;
  logic rx_valid;

  wire take = tx_ready && i_tx_valid;
  wire half_done = (half_count == 3'(`PIX_HALF_CYCLES - 1));
  wire pclk_idle = !cap_rising;

  // Straps toward the device
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cap_rising <= 1'h0;
      strobe_rising <= 1'h0;
      config_sel <= `CONFIG_COMPANION;
      disp_ready <= 1'h0;
    end else if (i_clock_en) begin
      cap_rising <= i_capture_rising;
      strobe_rising <= i_strobe_rising;
      config_sel <= `CONFIG_COMPANION;
      disp_ready <= i_rx_ready;
    end
  end

  // One pixel clock period per accepted pixel
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= TX_IDLE;
      half_count <= 3'h0;
      pclk <= 1'h1;
      tx_ready <= 1'h0;
      tx_word <= `LINK_WORD_RESET;
    end else if (i_clock_en) begin
      half_count <= (state == TX_IDLE || half_done) ? 3'h0
                    : half_count + 3'h1;
      case (state)
        TX_IDLE: begin
          pclk <= pclk_idle;
          tx_ready <= link.link_ready && !take;
          if (take) begin
            tx_word <= pack_pixel(i_map_mode, i_tx_pixel);
            state <= TX_SETUP;
          end
        end
        TX_SETUP: if (half_done) begin
          pclk <= !pclk_idle;
          state <= TX_HOLD;
        end
        TX_HOLD: if (half_done) begin
          pclk <= pclk_idle;
          state <= TX_IDLE;
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  // Sample outputs on the strobe edge of the recovered clock
  wire rclk = link.recovered_clock_out;
  wire strobe = strobe_rising ? (rclk && !rclk_prev)
                : (!rclk && rclk_prev);
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rclk_prev <= 1'h1;
      rx_pixel <= '0;
      rx_valid <= 1'h0;
    end else if (i_clock_en) begin
      rclk_prev <= rclk;
      rx_valid <= strobe;
      if (strobe) begin
        rx_pixel <= unpack_pixel(i_map_mode,
          {link.control_line_out, link.parallel_word_out});
      end
    end
  end

  // Outputs straight from flip-flops
  assign link.pixel_clock_in = pclk;
  assign link.parallel_word_in = tx_word.parallel_word;
  assign link.control_line_in = tx_word.control_line;
  assign link.ser_edge_select = cap_rising;
  assign link.des_edge_select = strobe_rising;
  assign link.link_config = config_sel;
  assign link.display_ready = disp_ready;
  assign o_tx_ready = tx_ready;
  assign o_rx_pixel = rx_pixel;
  assign o_rx_valid = rx_valid;

endmodule

//--- verif/pixel_link_bit_mapping_monitor.sv
// Purpose: Timing checks on the pins joining the two link ends
// Assumes: One clock; both straps are static between resets
// Notes: Capture level equals the capture select, strobe level the
// Notes: strobe select
`include "pixel_link_regs.svh"

module pixel_link_bit_mapping_monitor (
  input wire logic i_clock, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic pixel_clock_in, // Host pixel clock
  input wire logic [`PIX_DATA_W-1:0] parallel_word_in, // Host word
  input wire logic [`PIX_CTRL_W-1:0] control_line_in, // Host controls
  input wire logic ser_edge_select, // Capture edge strap
  input wire logic des_edge_select, // Strobe edge strap
  input wire logic [1:0] link_config, // Pairing straps
  input wire logic display_ready, // Display accepts words
  input wire logic link_ready, // Device accepts words
  input wire logic recovered_clock_out, // Output strobe
  input wire logic [`PIX_DATA_W-1:0] parallel_word_out, // Output word
  input wire logic [`PIX_CTRL_W-1:0] control_line_out // Output controls
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  // Edges that move a clock to its active level
  sequence cap_edge;
    $changed(pixel_clock_in) && (pixel_clock_in == ser_edge_select);
  endsequence
  sequence strobe_edge;
    $changed(recovered_clock_out) &&
      (recovered_clock_out == des_edge_select);
  endsequence

  // Host side pins around the capture edge
  AST_CAPTURE_HOLD: assert property (cap_edge |->
    ($stable(parallel_word_in) && $stable(control_line_in)) [*7])
    else $error("host word moved near capture edge");
  AST_CAPTURE_WIDTH: assert property (cap_edge |->
    (pixel_clock_in == ser_edge_select) [*6] ##1
    (pixel_clock_in != ser_edge_select))
    else $error("pixel clock active phase not six cycles");
  AST_WORD_AT_IDLE: assert property (
    $changed({control_line_in, parallel_word_in}) |->
    (pixel_clock_in != ser_edge_select))
    else $error("host word changed in active clock phase");

  // Display side pins around the strobe edge, then ready handshake and strap checks
  AST_OUT_AT_IDLE: assert property (
    $changed({control_line_out, parallel_word_out}) |->
    (recovered_clock_out != des_edge_select))
    else $error("output word changed in strobe phase");
  AST_STROBE_SHAPE: assert property (strobe_edge |->
    (recovered_clock_out == des_edge_select) [*3] ##1
    (recovered_clock_out != des_edge_select))
    else $error("strobe phase not three cycles");
  AST_STROBE_HOLD: assert property (strobe_edge |->
    $stable({control_line_out, parallel_word_out}) [*3])
    else $error("output word moved around strobe");
  AST_OUT_THEN_STROBE: assert property (
    $changed({control_line_out, parallel_word_out}) |-> ##2 strobe_edge)
    else $error("no strobe two cycles after output change");
  AST_POP_READY: assert property (
    $changed({control_line_out, parallel_word_out}) |->
    $past(display_ready))
    else $error("word popped while display not ready");
  AST_TAKE_READY: assert property (
    $changed({control_line_in, parallel_word_in}) |-> $past(link_ready, 2))
    else $error("host word taken while link not ready");
  AST_CONFIG_LOW: assert property (link_config == 2'h0)
    else $error("pairing straps not low");
endmodule

//--- verif/pixel_link_bit_mapping_tb_top.sv
// Purpose: Self-checking bench for both ends of the pixel link
// Assumes: Straps and mapping change only while in reset
// Notes: First four words after lock start are dropped on purpose
`include "pixel_link_regs.svh"
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  num_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); end end

module pixel_link_bit_mapping_tb_top import pixel_link_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic clock_en = 1'h1;
  logic cap_r = 1'h0;
  logic str_r = 1'h0;
  logic tx_valid = 1'h0;
  logic rx_ready = 1'h1;
  map_mode_t mode = MAP_NATIVE_24;
  pixel_t tx_pixel = '0;
  pixel_t rx_pixel;
  logic tx_ready, rx_valid, locked, overflow;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] seed = 32'h78f9_8694;
  pixel_t exp_px[$];
  link_word_t exp_wd[$];

  // 50 MHz clock
  always #10 clock = ~clock;

  pixel_link_if link_bus();
  pixel_link_device u_pixel_link_device (.i_clock(clock),
    .i_resetn(resetn), .i_clock_en(clock_en), .link(link_bus),
    .o_locked(locked), .o_overflow(overflow));
  pixel_link_partner u_pixel_link_partner (.i_clock(clock),
    .i_resetn(resetn), .i_clock_en(clock_en), .i_map_mode(mode),
    .i_capture_rising(cap_r), .i_strobe_rising(str_r),
    .i_tx_pixel(tx_pixel), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_rx_pixel(rx_pixel), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
    .link(link_bus));
  pixel_link_bit_mapping_monitor mon (.i_clock(clock), .i_resetn(resetn),
    .pixel_clock_in(link_bus.pixel_clock_in),
    .parallel_word_in(link_bus.parallel_word_in),
    .control_line_in(link_bus.control_line_in),
    .ser_edge_select(link_bus.ser_edge_select),
    .des_edge_select(link_bus.des_edge_select),
    .link_config(link_bus.link_config),
    .display_ready(link_bus.display_ready),
    .link_ready(link_bus.link_ready),
    .recovered_clock_out(link_bus.recovered_clock_out),
    .parallel_word_out(link_bus.parallel_word_out),
    .control_line_out(link_bus.control_line_out));

  // Output pins as one link word
  wire link_word_t out_wd = {link_bus.control_line_out,
    link_bus.parallel_word_out};

  // Random source and expected mapping
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic pixel_t rand_pixel();
    logic [63:0] r;
    seed = lfsr(seed);
    r[31:0] = seed;
    seed = lfsr(seed);
    r[63:32] = seed;
    return r[32:0];
  endfunction
  function automatic link_word_t wire_of(map_mode_t m, pixel_t p);
    if (m == MAP_18_CTRL)
      return {p.pixel_valid, p.frame_sync, p.line_sync, p.blue[5:0],
              p.spare_signal[5:4], p.green[5:0], p.spare_signal[3:2],
              p.red[5:0], p.spare_signal[1:0]};
    if (m == MAP_18_EMBED)
      return {3'h0, p.spare_signal[2:0], p.pixel_valid, p.frame_sync,
              p.line_sync, p.blue[5:0], p.green[5:0], p.red[5:0]};
    return {p.pixel_valid, p.frame_sync, p.line_sync, p.blue, p.green,
            p.red};
  endfunction
  function automatic pixel_t seen_of(map_mode_t m, pixel_t p);
    pixel_t r;
    r = p;
    if (m != MAP_NATIVE_24) begin
      r.red[7:6] = 2'h0;
      r.green[7:6] = 2'h0;
      r.blue[7:6] = 2'h0;
    end
    if (m == MAP_NATIVE_24) r.spare_signal = 6'h00;
    if (m == MAP_18_EMBED) r.spare_signal[5:3] = 3'h0;
    return r;
  endfunction

  // Received pixels and output wire words against expectations
  always @(negedge clock) begin
    if (rx_valid === 1'b1) begin
      if (exp_px.size() == 0) begin
        `CHECK(1'b1, 1'b0)
      end else begin
        `CHECK(rx_pixel, exp_px[0])
        `CHECK(out_wd, exp_wd[0])
        void'(exp_px.pop_front());
        void'(exp_wd.pop_front());
      end
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic do_reset(input logic c, input logic s, input map_mode_t m);
    @(negedge clock);
    resetn = 1'h0;
    cap_r = c;
    str_r = s;
    mode = m;
    rx_ready = 1'h1;
    repeat (10) @(negedge clock);
    resetn = 1'h1;
    repeat (3) @(negedge clock);
  endtask

  // Offer one pixel; a short limit lets the caller probe refusal
  task automatic send(input pixel_t p, input bit keep, input int limit,
                      output bit ok);
    int n;
    n = 0;
    @(negedge clock);
    tx_pixel = p;
    tx_valid = 1'h1;
    while (tx_ready !== 1'b1 && n < limit) begin
      @(negedge clock);
      n++;
    end
    ok = (tx_ready === 1'b1);
    if (!ok) tx_valid = 1'h0;
    else begin
      if (keep) begin
        exp_px.push_back(seen_of(mode, p));
        exp_wd.push_back(wire_of(mode, p));
      end
      @(negedge clock);
      tx_valid = 1'h0;
    end
    if (!ok && limit >= 2000) begin
      `CHECK(ok, 1'b1)
      test_done();
    end
  endtask

  task automatic wait_empty();
    int n;
    n = 0;
    while (exp_px.size() != 0 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    `CHECK(n < 3000, 1'b1)
    if (n >= 3000) test_done();
    repeat (20) @(negedge clock);
  endtask

  // Every strap pair, every mapping, lock, stall and relock
  initial begin
    bit ok;
    pixel_t corner[4];
    corner = '{33'h0_0000_0000, 33'h1_ffff_ffff, 33'h1_5555_5555,
               33'h0_aaaa_aaaa};
    for (int cfg = 0; cfg < 4; cfg++) begin
      do_reset(cfg[0], cfg[1], map_mode_t'(cfg % 3));
      `CHECK(locked, 1'b0)
      `CHECK(link_bus.link_config, 2'h0)
      for (int i = 0; i < 4; i++) send(corner[i], 0, 2000, ok);
      repeat (20) @(negedge clock);
      `CHECK(locked, 1'b1)
      for (int i = 0; i < 4; i++) send(corner[i], 1, 2000, ok);
      for (int i = 0; i < 24; i++) begin
        rx_ready = seed[3] | seed[4];
        send(rand_pixel(), 1, 2000, ok);
      end
      rx_ready = 1'h1;
      wait_empty();
      // Display stall until the link stops taking pixels
      rx_ready = 1'h0;
      ok = 1'b1;
      for (int i = 0; i < 30 && ok; i++) send(rand_pixel(), 1, 60, ok);
      `CHECK(link_bus.link_ready, 1'b0)
      `CHECK(overflow, 1'b0)
      rx_ready = 1'h1;
      wait_empty();
      `CHECK(overflow, 1'b0)
      // Long silence drops lock, then it relearns
      repeat (600) @(negedge clock);
      `CHECK(locked, 1'b0)
      for (int i = 0; i < 4; i++) send(corner[i], 0, 2000, ok);
      for (int i = 0; i < 3; i++) send(rand_pixel(), 1, 2000, ok);
      wait_empty();
      `CHECK(locked, 1'b1)
      $display("test cfg %0d done", cfg);
    end
    test_done();
  end
endmodule
